// ==== logic/cis_steer.v ====
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cis_regs.vh"

// Function
// - card request goes to line chosen in 03h
// - four-bit code maps to the ten lines
// - status changes go to line from 05h
// - host enable bit sends status to host pin
// - unassigned lines stay undriven
// - resume and detect enable drive wake pin
// - level mode drives low while raised
// - edge mode rests low, high while raised
// - global bit one picks level or edge
// - global bit three forces level on line fourteen
// - host pin pulses low three clocks
// - io card sources include gated status pin
// - memory card sources detect battery ready gpi
// - change bits clear on read or write-one
// - card type bit selects io or memory
module cis_steer #(
   parameter NLINES = `CIS_NLINES
) (
   input wire clk,
   input wire rst_n,
   input wire [7:0] addr,
   input wire [7:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [7:0] rdata,
   input wire card_ireq_n,
   input wire cd1_n,
   input wire cd2_n,
   input wire bvd1,
   input wire bvd2,
   input wire ready,
   input wire gp_input,
   output wire [NLINES-1:0] irq_o,
   output wire [NLINES-1:0] irq_oe,
   output reg host_int_n,
   output reg wake_out_n,
   output wire int_o
);

   localparam [4*NLINES-1:0] CODES = `CIS_IRQ_CODES;

   reg [7:0] intctl_q;
   reg [7:0] stcfg_q;
   reg [7:0] cdgen_q;
   reg [7:0] global_q;
   reg [`CIS_CHG_W-1:0] chg_q;
   reg [`CIS_CHG_W-1:0] chg_d;
   reg [`CIS_EVT_W-1:0] evt_q;
   reg [`CIS_EVT_W-1:0] evt_d;
   reg [`CIS_EVT_W-1:0] mask_q;
   reg [7:0] rdata_d;
   reg cd1_prev_q;
   reg cd2_prev_q;
   reg bvd1_prev_q;
   reg bvd2_prev_q;
   reg ready_prev_q;
   reg gpi_prev_q;
   reg ireq_prev_q;
   reg stat_prev_q;
   reg [1:0] pulse_q;
   reg [1:0] pulse_d;

   wire io_card;
   wire [3:0] ireq_sel;
   wire [3:0] stat_sel;
   wire host_en;
   wire ireq_act;
   wire cd_change;
   wire bvd1_change;
   wire bvd2_change;
   wire ready_change;
   wire stsch_fall;
   wire gpi_edge;
   wire [`CIS_CHG_W-1:0] chg_set;
   wire [`CIS_CHG_W-1:0] chg_en;
   wire stat_pend;
   wire stat_rise;
   wire ireq_fall;
   wire [`CIS_EVT_W-1:0] evt_set;
   wire wr_chg;
   wire rd_chg;
   wire pulse_load;

   // decoded control
   assign io_card = intctl_q[`CIS_INTCTL_IOCARD];
   assign ireq_sel = intctl_q[`CIS_INTCTL_SEL_HI:`CIS_INTCTL_SEL_LO];
   assign stat_sel = stcfg_q[`CIS_STCFG_SEL_HI:`CIS_STCFG_SEL_LO];
   assign host_en = intctl_q[`CIS_INTCTL_HOSTEN];

   // card request is active low on io cards only
   assign ireq_act = io_card & ~card_ireq_n;

   // pin change detection
   assign cd_change = (cd1_n ^ cd1_prev_q) | (cd2_n ^ cd2_prev_q);
   assign bvd1_change = bvd1 ^ bvd1_prev_q;
   assign bvd2_change = bvd2 ^ bvd2_prev_q;
   assign ready_change = ready ^ ready_prev_q;
   assign stsch_fall = bvd1_prev_q & ~bvd1;
   assign gpi_edge = cdgen_q[`CIS_CDGEN_GPIPOL] ?
                     (gpi_prev_q & ~gp_input) : (~gpi_prev_q & gp_input);

   // change sources by card type
   assign chg_set[`CIS_CHG_BVD1] = io_card ?
      (intctl_q[`CIS_INTCTL_RIEN] & stsch_fall) : bvd1_change;
   assign chg_set[`CIS_CHG_BVD2] = ~io_card & bvd2_change;
   assign chg_set[`CIS_CHG_READY] = ~io_card & ready_change;
   assign chg_set[`CIS_CHG_CD] = cd_change;
   assign chg_set[`CIS_CHG_GPI] = cdgen_q[`CIS_CDGEN_GPIEN] & gpi_edge;

   // enables that turn a change into a pending status interrupt
   assign chg_en[`CIS_CHG_BVD1] = stcfg_q[`CIS_CHG_BVD1];
   assign chg_en[`CIS_CHG_BVD2] = stcfg_q[`CIS_CHG_BVD2] & ~io_card;
   assign chg_en[`CIS_CHG_READY] = stcfg_q[`CIS_CHG_READY] & ~io_card;
   assign chg_en[`CIS_CHG_CD] = stcfg_q[`CIS_STCFG_CDEN];
   assign chg_en[`CIS_CHG_GPI] = 1'b1;

   assign stat_pend = |(chg_q & chg_en);
   assign stat_rise = stat_pend & ~stat_prev_q;
   assign ireq_fall = ireq_prev_q & ireq_act;

   assign wr_chg = wr_en & (addr == `CIS_IDX_CHG);
   assign rd_chg = rd_en & (addr == `CIS_IDX_CHG);

   // change register, set wins over clear
   always @* begin
      chg_d = chg_q;
      if (global_q[`CIS_GLB_WB]) begin
         if (wr_chg) begin
            chg_d = chg_q & ~wdata[`CIS_CHG_W-1:0];
         end
      end else if (rd_chg) begin
         chg_d = {`CIS_CHG_W{1'b0}};
      end
      chg_d = chg_d | chg_set;
   end

   // own event register
   assign evt_set[`CIS_EVT_STAT] = stat_rise;
   assign evt_set[`CIS_EVT_IREQ] = ireq_fall;
   assign evt_set[`CIS_EVT_CD] = cd_change;

   always @* begin
      evt_d = evt_q;
      if (wr_en && (addr == `CIS_IDX_EVT)) begin
         evt_d = evt_q & ~wdata[`CIS_EVT_W-1:0];
      end
      evt_d = evt_d | evt_set;
   end

   assign int_o = |(evt_q & mask_q);

   // read mux
   always @* begin
      rdata_d = `CIS_RST_BYTE;
      if (rd_en) begin
         case (addr)
            `CIS_IDX_INTCTL: rdata_d = intctl_q;
            `CIS_IDX_CHG: rdata_d = {{(8-`CIS_CHG_W){1'b0}}, chg_q};
            `CIS_IDX_STCFG: rdata_d = stcfg_q;
            `CIS_IDX_CDGEN: rdata_d = cdgen_q;
            `CIS_IDX_GLOBAL: rdata_d = global_q;
            `CIS_IDX_EVT: rdata_d = {{(8-`CIS_EVT_W){1'b0}}, evt_q};
            `CIS_IDX_MASK: rdata_d = {{(8-`CIS_EVT_W){1'b0}}, mask_q};
            default: rdata_d = `CIS_RST_BYTE;
         endcase
      end
   end

   // register writes and state
   always @(posedge clk) begin
      if (!rst_n) begin
         intctl_q <= `CIS_RST_BYTE;
         stcfg_q <= `CIS_RST_BYTE;
         cdgen_q <= `CIS_RST_BYTE;
         global_q <= `CIS_RST_BYTE;
         chg_q <= {`CIS_CHG_W{1'b0}};
         evt_q <= {`CIS_EVT_W{1'b0}};
         mask_q <= {`CIS_EVT_W{1'b0}};
         rdata <= `CIS_RST_BYTE;
      end else begin
         chg_q <= chg_d;
         evt_q <= evt_d;
         rdata <= rdata_d;
         if (wr_en) begin
            case (addr)
               `CIS_IDX_INTCTL: intctl_q <= wdata;
               `CIS_IDX_STCFG: stcfg_q <= wdata;
               `CIS_IDX_CDGEN: cdgen_q <= wdata;
               `CIS_IDX_GLOBAL: global_q <= wdata;
               `CIS_IDX_MASK: mask_q <= wdata[`CIS_EVT_W-1:0];
               default: mask_q <= mask_q;
            endcase
         end
      end
   end

   // previous samples; pin samples load from the pins during reset, request and status history load inactive
   always @(posedge clk) begin
      if (!rst_n) begin
         cd1_prev_q <= cd1_n;
         cd2_prev_q <= cd2_n;
         bvd1_prev_q <= bvd1;
         bvd2_prev_q <= bvd2;
         ready_prev_q <= ready;
         gpi_prev_q <= gp_input;
         ireq_prev_q <= 1'b1;
         stat_prev_q <= 1'b0;
      end else begin
         cd1_prev_q <= cd1_n;
         cd2_prev_q <= cd2_n;
         bvd1_prev_q <= bvd1;
         bvd2_prev_q <= bvd2;
         ready_prev_q <= ready;
         gpi_prev_q <= gp_input;
         ireq_prev_q <= ~ireq_act;
         stat_prev_q <= stat_pend;
      end
   end

   // host pin pulse
   assign pulse_load = host_en & stat_rise;

   always @* begin
      pulse_d = pulse_q;
      if (pulse_load) begin
         pulse_d = `CIS_HOST_PULSE;
      end else if (pulse_q != `CIS_CNT_ZERO) begin
         pulse_d = pulse_q - `CIS_CNT_ONE;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         pulse_q <= `CIS_CNT_ZERO;
         host_int_n <= 1'b1;
         wake_out_n <= 1'b1;
      end else begin
         pulse_q <= pulse_d;
         host_int_n <= ~(pulse_load | (pulse_q > `CIS_CNT_ONE));
         wake_out_n <= ~(cdgen_q[`CIS_CDGEN_RESUME] & stcfg_q[`CIS_STCFG_CDEN]
                         & chg_q[`CIS_CHG_CD]);
      end
   end

   // per line steering
   genvar i;
   generate
      for (i = 0; i < NLINES; i = i + 1) begin : g_line
         wire ireq_hit;
         wire stat_hit;
         wire level_mode;
         assign ireq_hit = io_card & (ireq_sel != `CIS_SEL_NONE)
                           & (ireq_sel == CODES[4*i+3:4*i]);
         assign stat_hit = ~host_en & (stat_sel != `CIS_SEL_NONE)
                           & (stat_sel == CODES[4*i+3:4*i]);
         assign level_mode = global_q[`CIS_GLB_LEVEL]
                             | ((i == `CIS_IRQ14_POS) & global_q[`CIS_GLB_IRQ14]);
         cis_line u_line (
            .clk(clk),
            .rst_n(rst_n),
            .ireq_hit(ireq_hit),
            .stat_hit(stat_hit),
            .ireq_act(ireq_act),
            .stat_act(stat_pend),
            .level_mode(level_mode),
            .irq_o(irq_o[i]),
            .irq_oe(irq_oe[i])
         );
      end
   endgenerate

endmodule // cis_steer

`default_nettype wire

// ==== logic/cis_regs.vh ====
`ifndef CIS_REGS_VH
`define CIS_REGS_VH

// register indexes
`define CIS_IDX_INTCTL 8'h03
`define CIS_IDX_CHG 8'h04
`define CIS_IDX_STCFG 8'h05
`define CIS_IDX_CDGEN 8'h16
`define CIS_IDX_GLOBAL 8'h1e
`define CIS_IDX_EVT 8'h40
`define CIS_IDX_MASK 8'h41

// interrupt and general control fields
`define CIS_INTCTL_SEL_HI 3
`define CIS_INTCTL_SEL_LO 0
`define CIS_INTCTL_HOSTEN 4
`define CIS_INTCTL_IOCARD 5
`define CIS_INTCTL_RIEN 7

// status interrupt configuration fields
`define CIS_STCFG_SEL_HI 7
`define CIS_STCFG_SEL_LO 4
`define CIS_STCFG_CDEN 3

// card detect and general control fields
`define CIS_CDGEN_GPIEN 2
`define CIS_CDGEN_GPIPOL 3
`define CIS_CDGEN_RESUME 4

// global control fields
`define CIS_GLB_LEVEL 1
`define CIS_GLB_WB 2
`define CIS_GLB_IRQ14 3

// change register bits
`define CIS_CHG_BVD1 0
`define CIS_CHG_BVD2 1
`define CIS_CHG_READY 2
`define CIS_CHG_CD 3
`define CIS_CHG_GPI 4
`define CIS_CHG_W 5

// own event bits
`define CIS_EVT_STAT 0
`define CIS_EVT_IREQ 1
`define CIS_EVT_CD 2
`define CIS_EVT_W 3

// irq lines 3,4,5,7,9,10,11,12,14,15, lowest line in the low nibble
`define CIS_NLINES 10
`define CIS_IRQ_CODES 40'hfecba97543
`define CIS_IRQ14_POS 8
`define CIS_SEL_NONE 4'h0

// host interrupt pulse length in clocks
`define CIS_HOST_PULSE 2'h3
`define CIS_CNT_ONE 2'h1
`define CIS_CNT_ZERO 2'h0

`define CIS_RST_BYTE 8'h00

`endif

// ==== logic/cis_line.v ====
`timescale 1ns/1ns
`default_nettype none

module cis_line (
   input wire clk,
   input wire rst_n,
   input wire ireq_hit,
   input wire stat_hit,
   input wire ireq_act,
   input wire stat_act,
   input wire level_mode,
   output reg irq_o,
   output reg irq_oe
);

   wire assigned;
   wire active;

   // either source raises a shared line
   assign assigned = ireq_hit | stat_hit;
   assign active = (ireq_hit & ireq_act) | (stat_hit & stat_act);

   always @(posedge clk) begin
      if (!rst_n) begin
         irq_o <= 1'b0;
         irq_oe <= 1'b0;
      end else if (!assigned) begin
         irq_o <= 1'b0;
         irq_oe <= 1'b0;
      end else if (level_mode) begin
         irq_o <= 1'b0;
         irq_oe <= active;
      end else begin
         irq_o <= active;
         irq_oe <= 1'b1;
      end
   end

endmodule // cis_line

`default_nettype wire

// ==== tb/cis_card.sv ====
`timescale 1ns/1ns
`default_nettype none
module cis_card (
   input wire logic clk,
   output var logic card_ireq_n,
   output var logic cd1_n,
   output var logic cd2_n,
   output var logic bvd1,
   output var logic bvd2,
   output var logic ready,
   output var logic gp_input
);
   // card seated, battery good, no request
   initial begin
      {card_ireq_n, cd1_n, cd2_n, bvd1, bvd2, ready, gp_input} = 7'h4e;
   end
   // pins move just after an edge
   task automatic drive(input logic [6:0] v);
      @(posedge clk);
      {card_ireq_n, cd1_n, cd2_n, bvd1, bvd2, ready, gp_input} <= v;
   endtask
endmodule // cis_card
`default_nettype wire

// ==== tb/cis_steer_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cis_regs.vh"
module cis_chk #(
   parameter NLINES = `CIS_NLINES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic card_ireq_n,
   input wire logic [NLINES-1:0] irq_o,
   input wire logic [NLINES-1:0] irq_oe,
   input wire logic host_int_n,
   input wire logic wake_out_n
);
   logic [7:0] ic_q, sc_q, cg_q, gl_q;
   logic [NLINES-1:0] cs, asg, x14;
   function automatic logic [NLINES-1:0] dec(input logic [3:0] c);
      for (int i = 0; i < NLINES; i++) dec[i] = 4'(`CIS_IRQ_CODES >> (4 * i)) == c;
   endfunction
   // shadow of the steering registers
   always @(posedge clk) begin
      if (!rst_n) begin
         {ic_q, sc_q, cg_q, gl_q} <= 32'h0;
      end else if (wr_en) begin
         if (addr == 8'h03) ic_q <= wdata;
         if (addr == 8'h05) sc_q <= wdata;
         if (addr == 8'h16) cg_q <= wdata;
         if (addr == 8'h1e) gl_q <= wdata;
      end
   end
   assign cs = ic_q[5] ? dec(ic_q[3:0]) : '0;
   assign asg = cs | (ic_q[4] ? '0 : dec(sc_q[7:4]));
   assign x14 = NLINES'(gl_q[3]) << 8;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_free_lines_hiz: assert property (!$past(wr_en) |-> (irq_oe & ~asg) == '0)
      else $error("unassigned irq line driven");
   a_level_drives_low: assert property (gl_q[1] && !$past(wr_en) |-> (irq_o & irq_oe) == '0)
      else $error("level mode line driven high");
   a_edge_lines_driven: assert property (!gl_q[1] && !$past(wr_en) |->
      (irq_oe & asg & ~x14) == (asg & ~x14))
      else $error("edge mode line not driven");
   a_irq14_level_only: assert property (gl_q[3] && !$past(wr_en) |-> !(irq_o[8] && irq_oe[8]))
      else $error("line fourteen driven high");
   a_card_req_line: assert property (ic_q[5] && !gl_q[1] && !$past(card_ireq_n) && !$past(wr_en)
      |-> (irq_o & cs & ~x14) == (cs & ~x14))
      else $error("card request not on its line");
   a_host_three_low: assert property ($fell(host_int_n) |-> !host_int_n [*3] ##1 host_int_n)
      else $error("host pulse length wrong");
   a_host_needs_en: assert property ($fell(host_int_n) |-> $past(ic_q[4]))
      else $error("host pulse without enable");
   a_wake_gated: assert property ($fell(wake_out_n) |-> $past(cg_q[4] && sc_q[3]))
      else $error("wake without enables");
   c_host: cover property ($fell(host_int_n));
   c_wake: cover property ($fell(wake_out_n));
   c_line: cover property (irq_oe != '0);
endmodule // cis_chk
bind cis_steer cis_chk #(.NLINES(NLINES)) cis_chk_i (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr_en(wr_en), .card_ireq_n(card_ireq_n), .irq_o(irq_o), .irq_oe(irq_oe),
   .host_int_n(host_int_n), .wake_out_n(wake_out_n));
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam logic [6:0] IDLE = 7'h4e;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] d;
   wire [7:0] rdata;
   wire card_ireq_n, cd1_n, cd2_n, bvd1, bvd2, ready, gp_input;
   wire [9:0] irq_o, irq_oe;
   wire host_int_n, wake_out_n, int_o;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   cis_steer cis_steer_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .card_ireq_n(card_ireq_n), .cd1_n(cd1_n), .cd2_n(cd2_n),
      .bvd1(bvd1), .bvd2(bvd2), .ready(ready), .gp_input(gp_input), .irq_o(irq_o),
      .irq_oe(irq_oe), .host_int_n(host_int_n), .wake_out_n(wake_out_n), .int_o(int_o));
   cis_card cis_card_i (.clk(clk), .card_ireq_n(card_ireq_n), .cd1_n(cd1_n), .cd2_n(cd2_n),
      .bvd1(bvd1), .bvd2(bvd2), .ready(ready), .gp_input(gp_input));
   initial forever #5 clk = ~clk;
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches = mismatches + 1;
         summarize;
      end
   end
   task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      chk("oe", irq_oe, 10'h000);
      rd(8'h03);
      chk("intctl", d, 10'h000);
      rd(8'h77);
      chk("unmapped", d, 10'h000);
      $display("test reset done");
   endtask
   task automatic t_map;
      logic [43:0] codes;
      logic [9:0] m;
      codes = 44'hfecba975430;
      for (int i = 0; i < 11; i++) begin
         m = (i == 0) ? 10'h000 : 10'h001 << (i - 1);
         wr(8'h03, {4'h2, codes[4*i +: 4]});
         cis_card_i.drive(IDLE ^ 7'h40);
         wt(2);
         chk("oe", irq_oe, m);
         chk("o", irq_o, m);
         cis_card_i.drive(IDLE);
         wt(2);
         chk("o", irq_o, 10'h000);
      end
      $display("test map done");
   endtask
   task automatic t_level;
      wr(8'h1e, 8'h02);
      wr(8'h03, 8'h23);
      cis_card_i.drive(IDLE ^ 7'h40);
      wt(2);
      chk("oe", irq_oe, 10'h001);
      chk("o", irq_o, 10'h000);
      cis_card_i.drive(IDLE);
      wt(2);
      chk("oe", irq_oe, 10'h000);
      wr(8'h1e, 8'h08);
      wr(8'h03, 8'h2e);
      wt(1);
      chk("oe", irq_oe, 10'h000);
      cis_card_i.drive(IDLE ^ 7'h40);
      wt(2);
      chk("oe", irq_oe, 10'h100);
      chk("o", irq_o, 10'h000);
      cis_card_i.drive(IDLE);
      $display("test level done");
   endtask
   task automatic t_stat;
      wr(8'h1e, 8'h00);
      wr(8'h03, 8'h00);
      wr(8'h05, 8'h38);
      cis_card_i.drive(IDLE ^ 7'h20);
      wt(2);
      chk("o", irq_o, 10'h001);
      rd(8'h04);
      chk("chg", d, 10'h008);
      wt(2);
      chk("o", irq_o, 10'h000);
      wr(8'h1e, 8'h04);
      cis_card_i.drive(IDLE);
      wt(2);
      rd(8'h04);
      wt(2);
      chk("o", irq_o, 10'h001);
      wr(8'h04, 8'h08);
      wt(2);
      chk("o", irq_o, 10'h000);
      $display("test status done");
   endtask
   task automatic t_host;
      int n;
      n = 0;
      wr(8'h1e, 8'h00);
      wr(8'h03, 8'hb0);
      wr(8'h05, 8'h31);
      cis_card_i.drive(IDLE ^ 7'h08);
      repeat (8) begin
         @(posedge clk);
         #1 n += !host_int_n;
      end
      chk("host low", 10'(n), 10'h003);
      chk("oe", irq_oe, 10'h000);
      $display("test host done");
   endtask
   task automatic t_wake;
      wr(8'h16, 8'h10);
      wr(8'h05, 8'h08);
      wr(8'h41, 8'h04);
      cis_card_i.drive(IDLE ^ 7'h18);
      wt(3);
      chk("wake", wake_out_n, 10'h000);
      chk("int", int_o, 10'h001);
      rd(8'h04);
      wr(8'h40, 8'h04);
      wt(2);
      chk("wake", wake_out_n, 10'h001);
      chk("int", int_o, 10'h000);
      wr(8'h41, 8'h00);
      cis_card_i.drive(IDLE ^ 7'h08);
      wt(3);
      chk("int", int_o, 10'h000);
      $display("test wake done");
   endtask
   task automatic t_share;
      wr(8'h03, 8'h25);
      wr(8'h05, 8'h50);
      wr(8'h16, 8'h04);
      rd(8'h04);
      cis_card_i.drive(7'h47);
      wt(2);
      chk("o", irq_o, 10'h004);
      chk("oe", irq_oe, 10'h004);
      cis_card_i.drive(7'h07);
      rd(8'h04);
      chk("chg", d, 10'h010);
      wt(2);
      chk("o", irq_o, 10'h004);
      cis_card_i.drive(7'h47);
      wt(2);
      chk("o", irq_o, 10'h000);
      wr(8'h03, 8'h00);
      wr(8'h05, 8'h54);
      cis_card_i.drive(7'h45);
      wt(2);
      chk("o", irq_o, 10'h004);
      rd(8'h04);
      chk("chg", d, 10'h004);
      wt(2);
      chk("o", irq_o, 10'h000);
      $display("test share done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wt(1);
      t_reset;
      t_map;
      t_level;
      t_stat;
      t_host;
      t_wake;
      t_share;
      summarize;
   end
endmodule // testbench
`default_nettype wire
